// file: core/kvn_pkg.sv
// Package with key codes, states, timing and carrier types for the keypad interpreter
package kvn_pkg;

  // Five-bit key codes, one distinct value per coded key; continue key has none
  localparam logic [4:0] KEY_D0     = 5'h00;
  localparam logic [4:0] KEY_D9     = 5'h09;
  localparam logic [4:0] KEY_PLUS   = 5'h0A;
  localparam logic [4:0] KEY_MINUS  = 5'h0B;
  localparam logic [4:0] KEY_VERB   = 5'h0C;
  localparam logic [4:0] KEY_NOUN   = 5'h0D;
  localparam logic [4:0] KEY_CLEAR  = 5'h0E;
  localparam logic [4:0] KEY_RELEASE = 5'h0F;
  localparam logic [4:0] KEY_COMMIT = 5'h10;
  localparam logic [4:0] KEY_LAMPRST = 5'h11;

  // Blank digit value on a lamp
  localparam logic [3:0] DIGIT_BLANK = 4'hF;

  // Class boundaries: codes at or above this value are upper range
  localparam logic [6:0] CLASS_SPLIT = 7'h28;

  // Load verbs and display verbs sharing the component pattern
  localparam logic [6:0] VERB_LOAD1  = 7'h15;
  localparam logic [6:0] VERB_LOAD12 = 7'h18;
  localparam logic [6:0] VERB_LOAD123 = 7'h19;
  localparam logic [6:0] VERB_DISP1  = 7'h01;
  localparam logic [6:0] VERB_DISP123 = 7'h05;

  // Data word length and flash timing
  localparam int          WORD_CHARS   = 5;
  localparam int          CLK_HZ       = 50_000_000;
  localparam int          FLASH_HALF_MS = 500;
  localparam int          FLASH_HALF_CYC = CLK_HZ / 1000 * FLASH_HALF_MS;

  // Entry states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_VERB = 4'b0010,
    ST_NOUN = 4'b0100,
    ST_DATA = 4'b1000
  } entry_t;

  // Two-digit code held as a pair of decimal digits
  typedef struct packed {
    logic [3:0] tens;
    logic [3:0] ones;
  } code2_t;

  // One data register display: sign lamps and five digits
  typedef struct packed {
    logic        plusOn;
    logic        minusOn;
    logic [19:0] digits;
  } dataReg_t;

  // Command passed to internal routines on commit
  typedef struct packed {
    code2_t     verb;
    code2_t     noun;
    logic       verbExtended;
    logic       nounMixed;
    logic [2:0] compMask;
  } command_t;

endpackage

// file: core/keypad_verb_noun_interpreter.sv
// Keypad verb and noun interpreter with data entry, ownership and lamp drive
module keypad_verb_noun_interpreter
  import kvn_pkg::*;
#(
  parameter int FlashHalfCyc = FLASH_HALF_CYC // Half period of the flash
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       keyStrobe,      // One-cycle pulse with a coded key
  input  wire logic [4:0] keyCode,        // Code of the pressed key
  input  wire logic       continueKey,    // Continue key pulse, no code
  input  wire logic       needData,       // Committed pair wants operator data
  input  wire logic       computing,      // Computer is busy
  input  wire logic       uplinkActive,   // Ground telemetry being accepted
  input  wire logic       internalReq,    // Internal routine asks for the display
  output logic            commitPulse,    // Commit of verb and noun pair
  output command_t        command,        // Committed command
  output logic            continuePulse,  // Continue forwarded to routines
  output logic            wordDone,       // A data word was committed
  output logic [2:0]      wordComp,       // Component the word belongs to
  output logic            wordDecimal,    // Word is decimal
  output logic            operatorOwns,   // Operator holds keyboard
  output logic            internalGrant,  // Internal routine may use display
  output logic [7:0]      verbLamps,      // Two verb digits
  output logic [7:0]      nounLamps,      // Two noun digits
  output dataReg_t [2:0]  dataLamps,      // Three data register displays
  output logic            activityCompLamp, // Computing lamp
  output logic            activityUplinkLamp // Uplink lamp
);

  // Decimal value of a two-digit code
  function automatic logic [6:0] codeVal(input code2_t c);
    codeVal = 7'(c.tens) * 7'hA + 7'(c.ones);
  endfunction

  // Component mask from verb: low digit 1..5 gives 1,2,3,12,123
  function automatic logic [2:0] compSel(input code2_t v);
    unique case (v.ones)
      4'h1:    compSel = 3'h1;
      4'h2:    compSel = 3'h2;
      4'h3:    compSel = 3'h4;
      4'h4:    compSel = 3'h3;
      4'h5:    compSel = 3'h7;
      default: compSel = 3'h0;
    endcase
  endfunction

  // Next component in mask after the present one
  function automatic logic [1:0] nextComp(input logic [2:0] m, input logic [1:0] cur);
    nextComp = 2'h3;
    for (int i = 2; i >= 0; i--) begin
      if (m[i] && (2'(i) > cur)) begin
        nextComp = 2'(i);
      end
    end
  endfunction

  // Lowest component selected by a mask, 3 when none is selected
  function automatic logic [1:0] firstComp(input logic [2:0] m);
    firstComp = 2'h3;
    for (int i = 2; i >= 0; i--) begin
      if (m[i]) begin
        firstComp = 2'(i);
      end
    end
  endfunction

  // State registers
  entry_t           st_q, st_d;          // Entry state
  code2_t           verb_q, verb_d;      // Stored verb
  code2_t           noun_q, noun_d;      // Stored noun
  logic             vCnt_q, vCnt_d;      // Verb digit count
  logic             nCnt_q, nCnt_d;      // Noun digit count
  logic             own_q, own_d;        // Operator ownership
  logic [2:0]       mask_q, mask_d;      // Components left to load
  logic [1:0]       comp_q, comp_d;      // Component being keyed
  logic [2:0]       chars_q, chars_d;    // Characters in current word
  logic             signed_q, signed_d;  // Word began with a sign
  dataReg_t [2:0]   regs_q, regs_d;      // Data displays
  logic             lampsOff_q, lampsOff_d; // Lamps forced off
  logic             commit_q, commit_d;
  command_t         cmd_q, cmd_d;
  logic             cont_q, cont_d;
  logic             wDone_q, wDone_d;
  logic [2:0]       wComp_q, wComp_d;
  logic             wDec_q, wDec_d;
  logic             grant_q, grant_d;
  logic             flashOn_q, flashOn_d;
  logic [31:0]      flCnt_q, flCnt_d;
  logic [7:0]       vl_q, vl_d, nl_q, nl_d;
  logic             actC_q, actC_d, actU_q, actU_d;

  logic isDigit;
  assign isDigit = keyStrobe && (keyCode <= KEY_D9);

  // Next-state logic for keyboard entry
  always_comb begin
    st_d = st_q; verb_d = verb_q; noun_d = noun_q; vCnt_d = vCnt_q; nCnt_d = nCnt_q;
    own_d = own_q;
    mask_d = mask_q; comp_d = comp_q; chars_d = chars_q; signed_d = signed_q;
    regs_d = regs_q; lampsOff_d = lampsOff_q; commit_d = 1'b0; cmd_d = cmd_q;
    wDone_d = 1'b0; wComp_d = wComp_q; wDec_d = wDec_q;
    cont_d = continueKey;
    if ((keyStrobe && keyCode != KEY_LAMPRST && keyCode != KEY_RELEASE) || continueKey) begin
      own_d = 1'b1;
    end
    if (keyStrobe) begin
      unique case (1'b1)
        (keyCode == KEY_VERB): begin
          st_d = ST_VERB; verb_d = '{DIGIT_BLANK, DIGIT_BLANK}; vCnt_d = 1'b0;
          lampsOff_d = 1'b0; // Keying lights the lamps again
        end
        (keyCode == KEY_NOUN): begin
          st_d = ST_NOUN; noun_d = '{DIGIT_BLANK, DIGIT_BLANK}; nCnt_d = 1'b0;
          lampsOff_d = 1'b0; // Keying lights the lamps again
        end
        (keyCode == KEY_LAMPRST): lampsOff_d = 1'b1;
        (keyCode == KEY_RELEASE): own_d = continueKey; // Continue in same cycle keeps it
        (keyCode == KEY_CLEAR): begin
          if (st_q == ST_DATA) begin
            chars_d = 3'h0; signed_d = 1'b0; regs_d[comp_q] = '0;
          end
        end
        (keyCode == KEY_PLUS || keyCode == KEY_MINUS): begin
          if (st_q == ST_DATA && chars_q == 3'h0) begin
            signed_d = 1'b1;
            regs_d[comp_q].plusOn = (keyCode == KEY_PLUS);
            regs_d[comp_q].minusOn = (keyCode == KEY_MINUS);
          end
        end
        (keyCode == KEY_COMMIT): begin
          if (st_q == ST_DATA) begin
            wDone_d = 1'b1; wComp_d = 3'(comp_q) + 3'h1; wDec_d = signed_q;
            mask_d[comp_q] = 1'b0;
            comp_d = nextComp(mask_q, comp_q);
            chars_d = 3'h0; signed_d = 1'b0;
            if (nextComp(mask_q, comp_q) == 2'h3) begin
              st_d = ST_IDLE;
            end
          end else if (st_q == ST_IDLE) begin
            commit_d = 1'b1; lampsOff_d = 1'b0;
            cmd_d.verb = verb_q; cmd_d.noun = noun_q;
            cmd_d.verbExtended = codeVal(verb_q) >= CLASS_SPLIT;
            cmd_d.nounMixed = codeVal(noun_q) >= CLASS_SPLIT;
            cmd_d.compMask = ((codeVal(verb_q) >= VERB_LOAD1 && codeVal(verb_q) <= VERB_LOAD123)
                || (codeVal(verb_q) >= VERB_DISP1 && codeVal(verb_q) <= VERB_DISP123))
                ? compSel(verb_q) : 3'h0;
            if (needData && cmd_d.compMask != 3'h0) begin
              st_d = ST_DATA; mask_d = cmd_d.compMask;
              comp_d = firstComp(cmd_d.compMask);
              chars_d = 3'h0; signed_d = 1'b0;
            end
          end
        end
        default: begin
          if (isDigit) begin
            unique case (st_q)
              ST_VERB: begin
                if (!vCnt_q) begin verb_d.tens = keyCode[3:0]; vCnt_d = 1'b1; end
                else begin verb_d.ones = keyCode[3:0]; st_d = ST_IDLE; end
              end
              ST_NOUN: begin
                if (!nCnt_q) begin noun_d.tens = keyCode[3:0]; nCnt_d = 1'b1; end
                else begin noun_d.ones = keyCode[3:0]; st_d = ST_IDLE; end
              end
              ST_DATA: begin
                // unsigned word leaves no stale sign lit
                if (chars_q == 3'h0 && !signed_q) begin
                  regs_d[comp_q].plusOn = 1'b0;
                  regs_d[comp_q].minusOn = 1'b0;
                end
                if (32'(chars_q) < WORD_CHARS) begin
                  regs_d[comp_q].digits = {regs_q[comp_q].digits[15:0], keyCode[3:0]};
                  chars_d = chars_q + 3'h1;
                end
              end
              ST_IDLE: ;
            endcase
          end
        end
      endcase
    end
  end

  // Flash, lamp and grant next values
  always_comb begin
    flCnt_d = flCnt_q + 32'h1; flashOn_d = flashOn_q;
    if (flCnt_q >= 32'(FlashHalfCyc - 1)) begin
      flCnt_d = '0; flashOn_d = !flashOn_q;
    end
    if (st_q == ST_DATA && !flashOn_q) begin
      vl_d = 8'hFF; nl_d = 8'hFF;
    end else begin
      vl_d = verb_d; nl_d = noun_d;
    end
    actC_d = computing && !lampsOff_d;
    actU_d = uplinkActive && !lampsOff_d;
    grant_d = internalReq && !own_d;
    // lamps stay dark while lamp reset holds
    if (lampsOff_d) begin
      vl_d = 8'hFF;
      nl_d = 8'hFF;
    end
  end

  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE; verb_q <= '{DIGIT_BLANK, DIGIT_BLANK};
      noun_q <= '{DIGIT_BLANK, DIGIT_BLANK}; vCnt_q <= 1'b0; nCnt_q <= 1'b0;
      own_q <= 1'b0; mask_q <= '0;
      comp_q <= '0; chars_q <= '0; signed_q <= 1'b0; regs_q <= '0; lampsOff_q <= 1'b0;
      commit_q <= 1'b0; cmd_q <= '0; cont_q <= 1'b0; wDone_q <= 1'b0; wComp_q <= '0;
      wDec_q <= 1'b0; grant_q <= 1'b0; flashOn_q <= 1'b1; flCnt_q <= '0;
      vl_q <= 8'hFF; nl_q <= 8'hFF; actC_q <= 1'b0; actU_q <= 1'b0;
    end else begin
      st_q <= st_d; verb_q <= verb_d; noun_q <= noun_d; vCnt_q <= vCnt_d; nCnt_q <= nCnt_d;
      own_q <= own_d;
      mask_q <= mask_d; comp_q <= comp_d; chars_q <= chars_d; signed_q <= signed_d;
      regs_q <= regs_d; lampsOff_q <= lampsOff_d; commit_q <= commit_d; cmd_q <= cmd_d;
      cont_q <= cont_d; wDone_q <= wDone_d; wComp_q <= wComp_d; wDec_q <= wDec_d;
      grant_q <= grant_d; flashOn_q <= flashOn_d; flCnt_q <= flCnt_d;
      vl_q <= vl_d; nl_q <= nl_d; actC_q <= actC_d; actU_q <= actU_d;
    end
  end

  assign commitPulse = commit_q;
  assign command = cmd_q;
  assign continuePulse = cont_q;
  assign wordDone = wDone_q;
  assign wordComp = wComp_q;
  assign wordDecimal = wDec_q;
  assign operatorOwns = own_q;
  assign internalGrant = grant_q;
  assign verbLamps = vl_q;
  assign nounLamps = nl_q;
  assign dataLamps = regs_q;
  assign activityCompLamp = actC_q;
  assign activityUplinkLamp = actU_q;

  // Verb key blanks verb lamps next cycle
  property p_verb_blank;
    @(posedge clk) disable iff (sys_rst)
      keyStrobe && keyCode == KEY_VERB |=> verb_q == 8'hFF;
  endproperty
  a_verb_blank: assert property (p_verb_blank) else $error("verb not blanked");

  property p_noun_blank;
    @(posedge clk) disable iff (sys_rst)
      keyStrobe && keyCode == KEY_NOUN |=> noun_q == 8'hFF && st_q == ST_NOUN;
  endproperty
  a_noun_blank: assert property (p_noun_blank) else $error("noun not blanked");

  property p_commit_only;
    @(posedge clk) disable iff (sys_rst)
      commit_q |-> $past(keyStrobe) && $past(keyCode) == KEY_COMMIT;
  endproperty
  a_commit_only: assert property (p_commit_only) else $error("commit without key");

  property p_release;
    @(posedge clk) disable iff (sys_rst)
      keyStrobe && keyCode == KEY_RELEASE && !continueKey |=> !own_q;
  endproperty
  a_release: assert property (p_release) else $error("ownership kept");

  property p_own;
    @(posedge clk) disable iff (sys_rst)
      keyStrobe && keyCode == KEY_VERB |=> own_q && !grant_q;
  endproperty
  a_own: assert property (p_own) else $error("ownership not taken");

  property p_lamp_off;
    @(posedge clk) disable iff (sys_rst)
      keyStrobe && keyCode == KEY_LAMPRST |=> verbLamps == 8'hFF && nounLamps == 8'hFF;
  endproperty
  a_lamp_off: assert property (p_lamp_off) else $error("lamps not off");

  property p_continue;
    @(posedge clk) disable iff (sys_rst) continueKey |=> continuePulse;
  endproperty
  a_continue: assert property (p_continue) else $error("continue lost");

  property p_word_len;
    @(posedge clk) disable iff (sys_rst)
      st_q == ST_DATA && isDigit && chars_q == 3'h5 |=> $stable(regs_q);
  endproperty
  a_word_len: assert property (p_word_len) else $error("word too long");

  // Commit key as sampled at a clock edge
  sequence s_commitKey;
    keyStrobe && keyCode == KEY_COMMIT;
  endsequence

  // Commit key while a code is half keyed
  sequence s_commitMidCode;
    s_commitKey ##0 (st_q == ST_VERB || st_q == ST_NOUN);
  endsequence

  // Commit key that closes a data word
  sequence s_wordCommit;
    s_commitKey ##0 st_q == ST_DATA;
  endsequence

  property p_no_early_commit;
    @(posedge clk) disable iff (sys_rst)
      s_commitMidCode |=> !commitPulse && st_q != ST_IDLE;
  endproperty
  a_no_early_commit: assert property (p_no_early_commit) else $error("early commit");

  property p_word_done;
    @(posedge clk) disable iff (sys_rst)
      s_wordCommit |=> wordDone && !commitPulse;
  endproperty
  a_word_done: assert property (p_word_done) else $error("word not closed");

  property p_verb_class;
    @(posedge clk) disable iff (sys_rst)
      s_commitKey ##0 st_q == ST_IDLE |=> command.verbExtended == (verb_q.tens >= 4'h4);
  endproperty
  a_verb_class: assert property (p_verb_class) else $error("verb class wrong");

endmodule

// file: tb/kvn_operator.sv
// Operator model that presses keyboard keys
module kvn_operator
  import kvn_pkg::*;
(
  input  wire logic       clk,
  output logic            keyStrobe,
  output logic [4:0]      keyCode,
  output logic            continueKey
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet key lines at start
  initial begin
    keyStrobe = 1'b0;
    keyCode = 5'h1F;
    continueKey = 1'b0;
  end

  // One coded press; the idle code shows the inverse value
  task automatic press(input logic [4:0] c);
    @(negedge clk);
    keyStrobe = 1'b1;
    keyCode = c;
    @(negedge clk);
    keyStrobe = 1'b0;
    keyCode = ~c;
  endtask

  task automatic proceed();
    @(negedge clk);
    continueKey = 1'b1;
    @(negedge clk);
    continueKey = 1'b0;
  endtask

  task automatic code(input logic [4:0] k, input logic [3:0] t, input logic [3:0] o);
    press(k);
    press({1'b0, t});
    press({1'b0, o});
  endtask

  // Data word: sign 1 plus, 2 minus, 0 none
  task automatic word(input logic [1:0] sgn, input logic [19:0] d, input logic spare);
    if (sgn == 2'h1) begin
      press(KEY_PLUS);
    end else if (sgn == 2'h2) begin
      press(KEY_MINUS);
    end
    for (int i = 4; i >= 0; i--) begin
      press({1'b0, d[i*4+:4]});
    end
    // a sixth character is offered and must be refused
    if (spare) begin
      press(5'h07);
    end
    press(KEY_COMMIT);
  endtask
endmodule

// file: tb/keypad_verb_noun_interpreter_tb_top.sv
// Self-checking bench for the keypad interpreter
module keypad_verb_noun_interpreter_tb_top
  import kvn_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic           clk, sys_rst, needData, computing, uplinkActive, internalReq;
  logic           keyStrobe, continueKey, commitPulse, continuePulse, wordDone;
  logic [4:0]     keyCode;
  command_t       command, lastCmd;
  logic [2:0]     wordComp, lastComp;
  logic           wordDecimal, lastDec, operatorOwns, internalGrant;
  logic [7:0]     verbLamps, nounLamps;
  dataReg_t [2:0] dataLamps;
  logic           activityCompLamp, activityUplinkLamp;
  int             num_errors = 0;
  int             checked = 0;
  int             commits = 0;
  int             conts = 0;
  int             words = 0;

  keypad_verb_noun_interpreter #(.FlashHalfCyc(4)) dut (
    .clk(clk), .sys_rst(sys_rst), .keyStrobe(keyStrobe), .keyCode(keyCode),
    .continueKey(continueKey), .needData(needData), .computing(computing),
    .uplinkActive(uplinkActive), .internalReq(internalReq),
    .commitPulse(commitPulse), .command(command), .continuePulse(continuePulse),
    .wordDone(wordDone), .wordComp(wordComp), .wordDecimal(wordDecimal),
    .operatorOwns(operatorOwns), .internalGrant(internalGrant),
    .verbLamps(verbLamps), .nounLamps(nounLamps), .dataLamps(dataLamps),
    .activityCompLamp(activityCompLamp), .activityUplinkLamp(activityUplinkLamp));

  kvn_operator op (.clk(clk), .keyStrobe(keyStrobe), .keyCode(keyCode),
    .continueKey(continueKey));

  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Catch one-cycle pulses and what they carry
  always @(posedge clk) begin
    if (commitPulse === 1'b1) begin
      commits++;
      lastCmd = command;
    end
    if (continuePulse === 1'b1) conts++;
    if (wordDone === 1'b1) begin
      words++;
      lastComp = wordComp;
      lastDec = wordDecimal;
    end
  end

  // Value compare
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Count compare
  task automatic chkN(input string nm, input int exp, input int got);
    checked++;
    if (got != exp) begin
      num_errors++;
      $display("[ERR] %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // Component mask expected from the verb's low digit
  function automatic logic [2:0] expMask(input logic [3:0] o);
    case (o)
      4'h1: expMask = 3'h1;
      4'h2: expMask = 3'h2;
      4'h3: expMask = 3'h4;
      4'h4: expMask = 3'h3;
      default: expMask = 3'h7;
    endcase
  endfunction

  // Commit and compare the command the design hands on
  task automatic commitCheck(input logic [3:0] vt, vo, nt, no);
    int c0;
    logic [2:0] em;
    c0 = commits;
    op.press(KEY_COMMIT);
    repeat (3) @(negedge clk);
    chkN("commits", c0 + 1, commits);
    chk("cmdVerb", {vt, vo}, lastCmd.verb);
    chk("cmdNoun", {nt, no}, lastCmd.noun);
    chk("verbExtended", vt >= 4'h4, lastCmd.verbExtended);
    chk("nounMixed", nt >= 4'h4, lastCmd.nounMixed);
    em = ((vt == 4'h0 || vt == 4'h2) && vo >= 4'h1 && vo <= 4'h5) ? expMask(vo) : 3'h0;
    chk("compMask", em, lastCmd.compMask);
  endtask

  // Verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    conclude();
  end

  // Main sequence
  initial begin
    logic [3:0]  vt, vo, nt, no;
    logic [19:0] d;
    int          offs, ons, w;
    void'($urandom(32'hD1FA));
    sys_rst = 1'b1;
    needData = 1'b0;
    computing = 1'b1;
    uplinkActive = 1'b0;
    internalReq = 1'b1;
    repeat (5) @(negedge clk);
    chk("verbLamps", 8'hFF, verbLamps);
    chk("commitPulse", 1'b0, commitPulse);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (3) @(negedge clk);
    chk("actComp", 1'b1, activityCompLamp);
    chk("actUplink", 1'b0, activityUplinkLamp);
    chk("internalGrant", 1'b1, internalGrant);
    // Verb key blanks, digits appear one by one
    op.press(KEY_VERB);
    repeat (2) @(negedge clk);
    chk("verbBlank", 8'hFF, verbLamps);
    chk("operatorOwns", 1'b1, operatorOwns);
    chk("internalGrant", 1'b0, internalGrant);
    op.press(5'h02);
    repeat (2) @(negedge clk);
    chk("verbTens", 4'h2, verbLamps[7:4]);
    op.press(KEY_COMMIT);
    op.press(5'h01);
    op.code(KEY_NOUN, 4'h0, 4'h1);
    repeat (2) @(negedge clk);
    chk("nounLamps", 8'h01, nounLamps);
    chkN("commits", 0, commits);
    commitCheck(4'h2, 4'h1, 4'h0, 4'h1);
    op.code(KEY_NOUN, 4'h4, 4'h7);
    commitCheck(4'h2, 4'h1, 4'h4, 4'h7);
    op.code(KEY_VERB, 4'h3, 4'h3);
    op.code(KEY_VERB, 4'h2, 4'h4);
    commitCheck(4'h2, 4'h4, 4'h4, 4'h7);
    // Load and display verbs first, then random pairs, both orders
    for (int i = 0; i < 16; i++) begin
      vt = (i < 10) ? ((i < 5) ? 4'h2 : 4'h0) : 4'($urandom % 10);
      vo = (i < 10) ? 4'(i % 5 + 1) : 4'($urandom % 9 + 1);
      nt = 4'($urandom % 10);
      no = 4'($urandom % 9 + 1);
      if (i % 2 == 1) op.code(KEY_NOUN, nt, no);
      op.code(KEY_VERB, vt, vo);
      if (i % 2 == 0) op.code(KEY_NOUN, nt, no);
      repeat (2) @(negedge clk);
      chk("verbLamps", {vt, vo}, verbLamps);
      chk("nounLamps", {nt, no}, nounLamps);
      commitCheck(vt, vo, nt, no);
    end
    op.proceed();
    repeat (3) @(negedge clk);
    chkN("continues", 1, conts);
    // Data words for components one to three, plus, minus, no sign
    for (int k = 0; k < 3; k++) begin
      vo = 4'(k + 1);
      needData = 1'b1;
      op.code(KEY_VERB, 4'h2, vo);
      op.code(KEY_NOUN, 4'h0, 4'h2);
      op.press(KEY_COMMIT);
      needData = 1'b0;
      repeat (4) @(negedge clk);
      offs = 0;
      ons = 0;
      repeat (24) begin
        @(negedge clk);
        if (verbLamps === 8'hFF) offs++;
        if (verbLamps === {4'h2, vo}) ons++;
      end
      chkN("flashOff", 12, offs);
      chkN("flashOn", 12, ons);
      for (int j = 0; j < 5; j++) d[j*4+:4] = 4'($urandom % 8);
      w = words;
      op.word((k == 2) ? 2'h0 : 2'(k + 1), d, k == 0);
      repeat (3) @(negedge clk);
      chkN("words", w + 1, words);
      chk("wordComp", k + 1, lastComp);
      chk("wordDecimal", k < 2, lastDec);
      chk("dataDigits", d, dataLamps[k].digits);
      chk("signLamps", (k == 2) ? 2'h0 : 2'(2 >> k),
          {dataLamps[k].plusOn, dataLamps[k].minusOn});
    end
    op.press(KEY_RELEASE);
    repeat (3) @(negedge clk);
    chk("releaseOwns", 1'b0, operatorOwns);
    chk("releaseGrant", 1'b1, internalGrant);
    uplinkActive = 1'b1;
    op.press(KEY_LAMPRST);
    repeat (3) @(negedge clk);
    chk("verbOff", 8'hFF, verbLamps);
    chk("nounOff", 8'hFF, nounLamps);
    chk("activityOff", 2'h0, {activityCompLamp, activityUplinkLamp});
    chk("resetOwns", 1'b0, operatorOwns);
    // Keying after a lamp reset shows digits again
    op.press(KEY_VERB);
    op.press(5'h05);
    repeat (2) @(negedge clk);
    chk("verbAfterLampRst", 8'h5F, verbLamps);
    // Reset in mid-run, with a verb half keyed
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("rstVerbLamps", 8'hFF, verbLamps);
    chk("rstNounLamps", 8'hFF, nounLamps);
    chk("rstActComp", 1'b1, activityCompLamp);
    chk("rstOwns", 1'b0, operatorOwns);
    conclude();
  end
endmodule
